// *** design/scd_cycle_counter.sv ***
// down counter for foreground test timeout
`timescale 1ns/1ps
`default_nettype none
module scd_cycle_counter #(
	parameter int W = 33
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic [W-1:0] value,
	input wire logic stop,
	// status
	output logic expired
);
	logic [W-1:0] cnt_q;
	logic run_q;
	// elaboration check: a one-bit counter cannot count down
	if (W < 2) begin : g_w_chk
		$error("counter width too small");
	end
	// counts down while running; expired is a one-cycle pulse once the count reaches one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (load) begin
				cnt_q <= value;
				run_q <= 1'b1;
			end else if (stop) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				if (cnt_q <= W'(1)) begin
					run_q <= 1'b0;
					expired <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** design/scd_decode.sv ***
// command decoder for protocol-out and send-diagnostic blocks
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"

// Operation
// - protocol-out block: B5h opcode, selector, specific, unit bit, length bytes 6-9
// - selector 00h and 07h-FFh reserved, 01h-06h are external protocols
// - unit bit one: length counts 512-byte units, padding bytes are 00h
// - unit bit zero: length is a plain byte count
// - protocol decides good status on receipt or after processing
// - diagnostic block 1Dh: function, page format, default test, offline flags, length
// - page format flag marks paged data, ignored when default test set
// - default test flag runs default test and ignores function code
// - code 001b starts short, 010b extended background test
// - code 100b aborts background test, valid only while one runs
// - 101b short foreground test within two minutes, 110b extended foreground
// - offline flags accepted and ignored
// - default test with nonzero list length gives illegal request, invalid CDB
// - list length must equal expected page length, else invalid CDB; the code checks it only when page format is set
// - spindle not at speed gives check condition, not ready
// - default or foreground test fault ends command with check condition
// - background test fault only logged, never ends a command in error
module scd_decode #(
	parameter int LEN_W = 41,
	parameter logic [32:0] FG_SHORT_CYC = 33'(`SCD_FG_SHORT_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// command block in
	input wire logic cmd_valid,
	input wire scd_pkg::scd_cdb_t cmd,
	// drive condition
	input wire logic spindle_ready,
	input wire logic data_done,
	input wire logic proto_done,
	input wire logic proto_early,
	input wire logic test_done,
	input wire logic test_fault,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// command results
	output logic end_valid,
	output scd_pkg::scd_end_t end_info,
	output logic xfer_start,
	output scd_pkg::scd_xfer_t xfer,
	output logic [2:0] test_start,
	output logic test_abort,
	output logic irq
);
	// elaboration checks: the scaled length needs room and the timer limit must be nonzero
	if (LEN_W < 41) begin : g_len_chk
		$error("length width too small for 512-byte units");
	end
	if (FG_SHORT_CYC == 33'h0_0000_0000) begin : g_fg_chk
		$error("foreground limit must be nonzero");
	end

	scd_pkg::scd_state_t state_q;
	logic bg_run_q;
	logic fg_q;
	logic [2:0] fc;
	logic dflt;
	logic pf;
	logic [15:0] plen;
	logic [15:0] page_len_q;
	logic [7:0] sel;
	logic sel_ok;
	logic fc_bad;
	logic fg_expired;
	logic [3:0] sts_q;
	logic [3:0] mask_q;
	logic [7:0] log_q;
	logic [3:0] ev;
	logic rd_sts;

	// ************************************************
	// field extraction
	// ************************************************
	assign sel = cmd.b1;
	assign sel_ok = (sel >= `SCD_PROT_FIRST) && (sel <= `SCD_PROT_LAST);
	assign fc = cmd.b1[7:5];
	assign dflt = cmd.b1[2];
	// offline flags in b1[1:0] deliberately unused
	assign pf = cmd.b1[4] & ~dflt;
	assign plen = {cmd.spec[7:0], cmd.b4};
	// reserved codes, and abort with nothing to abort
	assign fc_bad = (fc == 3'h3) || (fc == 3'h7) || ((fc == `SCD_FC_ABORT) && !bg_run_q);
	assign rd_sts = reg_rd && (reg_addr == `SCD_REG_IRQ);

	// ************************************************
	// command sequencing
	// ************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= scd_pkg::SCD_IDLE;
			end_valid <= 1'b0;
			end_info <= '0;
			xfer_start <= 1'b0;
			xfer <= '0;
			test_start <= 3'h0;
			test_abort <= 1'b0;
			fg_q <= 1'b0;
		end else begin
			end_valid <= 1'b0;
			xfer_start <= 1'b0;
			test_start <= 3'h0;
			test_abort <= 1'b0;
			case (state_q)
				scd_pkg::SCD_IDLE: begin
					if (cmd_valid && cmd.op == `SCD_OP_SECOUT) begin
						if (!sel_ok) begin
							end_info <= {`SCD_ST_CHECK, `SCD_SK_ILLEGAL, `SCD_ASC_INV_CDB};
							state_q <= scd_pkg::SCD_DONE;
						end else begin
							xfer.protocol <= sel;
							xfer.early_good <= proto_early;
							// 512-byte units; host pads with 00h
							if (cmd.b4[`SCD_INC512_BIT])
								xfer.bytes <= {cmd.len, 9'h000};
							else
								xfer.bytes <= {9'h000, cmd.len};
							xfer_start <= 1'b1;
							state_q <= scd_pkg::SCD_XFER;
						end
					end else if (cmd_valid && cmd.op == `SCD_OP_DIAG) begin
						if (!spindle_ready) begin
							end_info <= {`SCD_ST_CHECK, `SCD_SK_NOT_READY, `SCD_ASC_NONE};
							state_q <= scd_pkg::SCD_DONE;
						end else if (dflt && plen != 16'h0000) begin
							end_info <= {`SCD_ST_CHECK, `SCD_SK_ILLEGAL, `SCD_ASC_INV_CDB};
							state_q <= scd_pkg::SCD_DONE;
						end else if (!dflt && pf && plen != page_len_q) begin
							end_info <= {`SCD_ST_CHECK, `SCD_SK_ILLEGAL, `SCD_ASC_INV_CDB};
							state_q <= scd_pkg::SCD_DONE;
						end else if (!dflt && fc_bad) begin
							end_info <= {`SCD_ST_CHECK, `SCD_SK_ILLEGAL, `SCD_ASC_INV_CDB};
							state_q <= scd_pkg::SCD_DONE;
						end else if (dflt || fc == `SCD_FC_FG_SHORT || fc == `SCD_FC_FG_EXT) begin
							// default test treated as foreground short
							test_start <= dflt ? `SCD_FC_FG_SHORT : fc;
							fg_q <= 1'b1;
							state_q <= scd_pkg::SCD_FG;
						end else begin
							if (fc == `SCD_FC_BG_SHORT || fc == `SCD_FC_BG_EXT)
								test_start <= fc;
							if (fc == `SCD_FC_ABORT)
								test_abort <= 1'b1;
							end_info <= {`SCD_ST_GOOD, `SCD_SK_GOOD, `SCD_ASC_NONE};
							state_q <= scd_pkg::SCD_DONE;
						end
					end
				end
				scd_pkg::SCD_XFER: begin
					// early completion on receipt, else wait for processing
					if ((xfer.early_good && data_done) || proto_done) begin
						end_info <= {`SCD_ST_GOOD, `SCD_SK_GOOD, `SCD_ASC_NONE};
						state_q <= scd_pkg::SCD_DONE;
					end
				end
				scd_pkg::SCD_FG: begin
					if (test_done || fg_expired) begin
						fg_q <= 1'b0;
						if (test_fault || fg_expired)
							end_info <= {`SCD_ST_CHECK, `SCD_SK_HW_ERROR, `SCD_ASC_DIAG_FAIL};
						else
							end_info <= {`SCD_ST_GOOD, `SCD_SK_GOOD, `SCD_ASC_NONE};
						state_q <= scd_pkg::SCD_DONE;
					end
				end
				scd_pkg::SCD_DONE: begin
					end_valid <= 1'b1;
					state_q <= scd_pkg::SCD_IDLE;
				end
				default: state_q <= scd_pkg::SCD_IDLE;
			endcase
		end
	end

	// ************************************************
	// background test tracking and fault log
	// ************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bg_run_q <= 1'b0;
			log_q <= 8'h00;
		end else begin
			if (test_start == `SCD_FC_BG_SHORT || test_start == `SCD_FC_BG_EXT)
				bg_run_q <= 1'b1;
			else if (test_abort)
				bg_run_q <= 1'b0;
			else if (bg_run_q && !fg_q && test_done) begin
				bg_run_q <= 1'b0;
				// fault goes to the log only, no command status
				if (test_fault)
					log_q <= log_q + 8'h01;
			end
		end
	end

	// short foreground guard; extended test has no fixed bound
	scd_cycle_counter #(
		.W(33)
	) u_fg_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(test_start == `SCD_FC_FG_SHORT),
		.value(FG_SHORT_CYC),
		.stop(state_q != scd_pkg::SCD_FG),
		.expired(fg_expired)
	);

	// ************************************************
	// registers and interrupt
	// ************************************************
	// events: end, check, bg fault, bg done
	assign ev = {bg_run_q && !fg_q && test_done,
		bg_run_q && !fg_q && test_done && test_fault,
		end_valid && end_info.status == `SCD_ST_CHECK,
		end_valid};

	// set wins over read-clear so no event is lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sts_q <= 4'h0;
		end else begin
			sts_q <= (rd_sts ? 4'h0 : sts_q) | ev;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q <= 4'h0;
			page_len_q <= `SCD_PAGELEN_RST;
		end else if (reg_wr) begin
			if (reg_addr == `SCD_REG_MASK)
				mask_q <= reg_wdata[3:0];
			else if (reg_addr == `SCD_REG_PAGELEN)
				page_len_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((rd_sts ? 4'h0 : sts_q) | ev) & mask_q);
		end
	end

	// read data stand one cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == `SCD_REG_STAT)
				reg_rdata <= {10'h000, bg_run_q, fg_q, state_q};
			else if (reg_addr == `SCD_REG_IRQ)
				reg_rdata <= {12'h000, sts_q};
			else if (reg_addr == `SCD_REG_MASK)
				reg_rdata <= {12'h000, mask_q};
			else if (reg_addr == `SCD_REG_LOG)
				reg_rdata <= {8'h00, log_q};
			else if (reg_addr == `SCD_REG_PAGELEN)
				reg_rdata <= page_len_q;
			else
				reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	sequence s_bad_sel;
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_SECOUT && !sel_ok;
	endsequence
	sequence s_check_end;
		end_valid && end_info.key == `SCD_SK_ILLEGAL;
	endsequence
	sequence s_good_end;
		end_valid && end_info.status == `SCD_ST_GOOD;
	endsequence

	a_bad_selector_rejected: assert property (@(posedge clk) disable iff (!rst_b)
		s_bad_sel |-> ##2 s_check_end) else $error("reserved selector not rejected");
	a_unit_scale: assert property (@(posedge clk) disable iff (!rst_b)
		xfer_start && $past(cmd.b4[7]) |-> xfer.bytes[8:0] == 9'h000)
		else $error("512-byte unit scaling wrong");
	a_byte_count: assert property (@(posedge clk) disable iff (!rst_b)
		xfer_start && !$past(cmd.b4[7]) |-> xfer.bytes == {9'h000, $past(cmd.len)})
		else $error("byte count wrong");
	a_not_ready: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_DIAG && !spindle_ready
		|-> ##2 end_valid && end_info.key == `SCD_SK_NOT_READY)
		else $error("not ready missing");
	a_dflt_len_check: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_DIAG && spindle_ready
		&& dflt && plen != 16'h0000 |-> ##2 s_check_end)
		else $error("default test length not refused");
	a_bg_start_good: assert property (@(posedge clk) disable iff (!rst_b)
		test_start == `SCD_FC_BG_SHORT |-> ##1 end_valid && end_info.status == `SCD_ST_GOOD)
		else $error("background start not good");
	a_abort_needs_bg: assert property (@(posedge clk) disable iff (!rst_b)
		test_abort |-> $past(bg_run_q)) else $error("abort without background test");
	a_fg_fault_check: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_FG && test_done && test_fault
		|-> ##2 end_valid && end_info.status == `SCD_ST_CHECK)
		else $error("foreground fault not reported");
	a_bg_fault_logged: assert property (@(posedge clk) disable iff (!rst_b)
		bg_run_q && !fg_q && test_done && test_fault && !test_abort
		&& test_start == 3'h0 |=> log_q == $past(log_q) + 8'h01)
		else $error("background fault not logged");
	a_reserved_code: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_DIAG && spindle_ready
		&& !dflt && !pf && (fc == 3'h3 || fc == 3'h7) |-> ##2 s_check_end)
		else $error("reserved function code not rejected");
	a_page_len_check: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_DIAG && spindle_ready
		&& !dflt && pf && plen != page_len_q |-> ##2 s_check_end)
		else $error("page length mismatch not refused");
	a_early_good: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_XFER && xfer.early_good && data_done |-> ##2 s_good_end)
		else $error("early good status missing");
	a_wait_process: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_XFER && !xfer.early_good && !proto_done
		|=> state_q == scd_pkg::SCD_XFER) else $error("good status before processing");
	a_default_ignores_fc: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_IDLE && cmd_valid && cmd.op == `SCD_OP_DIAG && spindle_ready
		&& dflt && plen == 16'h0000 |=> test_start == `SCD_FC_FG_SHORT)
		else $error("default test not started");
	a_fg_timeout: assert property (@(posedge clk) disable iff (!rst_b)
		state_q == scd_pkg::SCD_FG && fg_expired |-> ##2 end_valid
		&& end_info.status == `SCD_ST_CHECK) else $error("foreground overrun not reported");
endmodule
`default_nettype wire

// *** design/scd_defines.svh ***
// constants for the command descriptor decoder
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_OP_SECOUT 8'hB5
`define SCD_OP_DIAG 8'h1D
`define SCD_PROT_FIRST 8'h01
`define SCD_PROT_LAST 8'h06
`define SCD_INC512_BIT 7
`define SCD_UNIT_SHIFT 9
`define SCD_FC_DEFAULT 3'h0
`define SCD_FC_BG_SHORT 3'h1
`define SCD_FC_BG_EXT 3'h2
`define SCD_FC_ABORT 3'h4
`define SCD_FC_FG_SHORT 3'h5
`define SCD_FC_FG_EXT 3'h6
`define SCD_SK_GOOD 4'h0
`define SCD_SK_NOT_READY 4'h2
`define SCD_SK_ILLEGAL 4'h5
`define SCD_SK_HW_ERROR 4'h4
`define SCD_ASC_NONE 8'h00
`define SCD_ASC_INV_CDB 8'h24
`define SCD_ASC_DIAG_FAIL 8'h40
`define SCD_ST_GOOD 8'h00
`define SCD_ST_CHECK 8'h02
`define SCD_FG_SHORT_MIN 2
`define SCD_CLK_MHZ 40
// one wide operand keeps the product from wrapping at 32 bits
`define SCD_FG_SHORT_CYC (`SCD_FG_SHORT_MIN * 60 * `SCD_CLK_MHZ * 64'd1000000)
`define SCD_REG_CTRL 4'h0
`define SCD_REG_STAT 4'h1
`define SCD_REG_IRQ 4'h2
`define SCD_REG_MASK 4'h3
`define SCD_REG_LOG 4'h4
`define SCD_REG_PAGELEN 4'h5
`define SCD_PAGELEN_RST 16'h0000
`endif

// *** design/scd_pkg.sv ***
// types for the command descriptor decoder
package scd_pkg;
	// one command block as delivered by the transport
	typedef struct packed {
		logic [11:0][7:0] b;
	} scd_unused_t;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] b1;
		logic [15:0] spec;
		logic [7:0] b4;
		logic [7:0] b5;
		logic [31:0] len;
		logic [7:0] b10;
		logic [7:0] ctrl;
	} scd_cdb_t;
	// command ending status
	typedef struct packed {
		logic [7:0] status;
		logic [3:0] key;
		logic [7:0] asc;
	} scd_end_t;
	// receive plan handed to the data-out path for a protocol command
	typedef struct packed {
		logic [7:0] protocol;
		logic [40:0] bytes;
		logic early_good;
	} scd_xfer_t;
	typedef enum logic [3:0] {
		SCD_IDLE = 4'b0001,
		SCD_XFER = 4'b0010,
		SCD_FG = 4'b0100,
		SCD_DONE = 4'b1000
	} scd_state_t;
endpackage

// *** verif/scd_partner.sv ***
// initiator and drive-side model answering the decoder
`timescale 1ns/1ps
`default_nettype none
module scd_partner (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// requests from the decoder
	input wire logic xfer_start,
	input wire logic [2:0] test_start,
	input wire logic test_abort,
	// pacing and fault choice of the bench
	input wire logic [9:0] lat,
	input wire logic fault_in,
	// answers
	output logic data_done,
	output logic proto_done,
	output logic test_done,
	output logic test_fault
);
	// ************
	// answer timers
	// ************
	int xc;
	int pc;
	int tc;
	logic f_q;
	// data lands lat cycles after the plan, processing twenty later
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xc <= 0;
			pc <= 0;
			tc <= 0;
			f_q <= 1'b0;
			data_done <= 1'b0;
			proto_done <= 1'b0;
			test_done <= 1'b0;
			test_fault <= 1'b0;
		end else begin
			data_done <= (xc == 1);
			proto_done <= (pc == 1);
			test_done <= (tc == 1);
			// fault line means nothing outside the done pulse, so it wanders
			test_fault <= (tc == 1) ? f_q : ~test_fault;
			xc <= xfer_start ? int'(lat) : (xc > 0 ? xc - 1 : 0);
			pc <= xfer_start ? int'(lat) + 20 : (pc > 0 ? pc - 1 : 0);
			// an abort kills the pending completion
			tc <= (test_start != 3'h0) ? int'(lat) : ((test_abort || tc == 0) ? 0 : tc - 1);
			if (test_start != 3'h0) begin
				f_q <= fault_in;
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/secproto_out_selftest_cmd_decode_test.sv ***
// self-checking bench for the command descriptor decoder
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.svh"
module secproto_out_selftest_cmd_decode_test;
	// ************
	// signals and models
	// ************
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cmd_valid = 1'b0;
	scd_pkg::scd_cdb_t cmd = '0;
	logic spindle_ready = 1'b1;
	logic proto_early = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [9:0] lat = 10'h00a;
	logic fault_in = 1'b0;
	logic data_done, proto_done, test_done, test_fault, end_valid, xfer_start, test_abort, irq;
	logic [15:0] reg_rdata;
	logic [2:0] test_start;
	scd_pkg::scd_end_t end_info;
	scd_pkg::scd_xfer_t xfer;
	int n_fail = 0;
	int checks_done = 0;
	int n_x = 0, n_p = 0, n_e = 0, n_ab = 0;
	logic [2:0] last_ts = 3'h0;
	logic [16:0] seed = 17'd99778;
	localparam scd_pkg::scd_end_t E_GOOD = {`SCD_ST_GOOD, `SCD_SK_GOOD, `SCD_ASC_NONE};
	localparam scd_pkg::scd_end_t E_ILL = {`SCD_ST_CHECK, `SCD_SK_ILLEGAL, `SCD_ASC_INV_CDB};
	localparam scd_pkg::scd_end_t E_NRDY = {`SCD_ST_CHECK, `SCD_SK_NOT_READY, `SCD_ASC_NONE};
	localparam scd_pkg::scd_end_t E_FLT = {`SCD_ST_CHECK, `SCD_SK_HW_ERROR, `SCD_ASC_DIAG_FAIL};
	// short foreground limit keeps the timeout case quick
	scd_decode #(.FG_SHORT_CYC(33'd100)) i_dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd(cmd), .spindle_ready(spindle_ready), .data_done(data_done), .proto_done(proto_done),
		.proto_early(proto_early), .test_done(test_done), .test_fault(test_fault),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .end_valid(end_valid), .end_info(end_info),
		.xfer_start(xfer_start), .xfer(xfer), .test_start(test_start),
		.test_abort(test_abort), .irq(irq));
	scd_partner i_far (.clk(clk), .rst_b(rst_b), .xfer_start(xfer_start),
		.test_start(test_start), .test_abort(test_abort), .lat(lat), .fault_in(fault_in),
		.data_done(data_done), .proto_done(proto_done), .test_done(test_done),
		.test_fault(test_fault));
	// clock of 25 ns
	initial forever #12.5 clk = ~clk;
	// event counters, pulses are one cycle wide
	always @(posedge clk) begin
		n_x += (xfer_start === 1'b1);
		n_p += (proto_done === 1'b1);
		n_e += (end_valid === 1'b1);
		n_ab += (test_abort === 1'b1);
		if (test_start !== 3'h0) last_ts = test_start;
	end
	// ************
	// helpers
	// ************
	function automatic logic [15:0] rnd();
		seed = {seed[15:0], seed[16] ^ seed[13]};
		return seed[15:0];
	endfunction
	function automatic scd_pkg::scd_cdb_t mk_sec(logic [7:0] sel, logic inc, logic [31:0] len);
		scd_pkg::scd_cdb_t c = '0;
		c.op = `SCD_OP_SECOUT;
		c.b1 = sel;
		c.b4 = {inc, 7'h00};
		c.len = len;
		return c;
	endfunction
	// offline flags drawn at random, they must change nothing
	function automatic scd_pkg::scd_cdb_t diag(logic [2:0] fc, logic pf, logic df, logic [15:0] n);
		scd_pkg::scd_cdb_t c = '0;
		logic [15:0] r = rnd();
		c.op = `SCD_OP_DIAG;
		c.b1 = {fc, pf, 1'b0, df, r[1:0]};
		c.spec[7:0] = n[15:8];
		c.b4 = n[7:0];
		return c;
	endfunction
	task automatic check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic check_end(input scd_pkg::scd_end_t e);
		checks_done++;
		if (end_info !== e) begin
			$display("ERROR end_info expected %h seen %h", e, end_info);
			n_fail++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one command, bounded wait for its ending, then compare
	task automatic run(input scd_pkg::scd_cdb_t c, input int lim, input scd_pkg::scd_end_t e);
		int i = 0;
		last_ts = 3'h0;
		@(posedge clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (end_valid !== 1'b1 && i < lim);
		if (end_valid !== 1'b1) begin
			$display("ERROR end_valid expected 1 seen 0");
			n_fail++;
			tally_and_finish();
		end
		check_end(e);
	endtask
	task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_r(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// ************
	// main sequence
	// ************
	initial begin
		logic [15:0] r, v;
		logic ok, ia;
		int k, x0, p0, e0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		reg_r(`SCD_REG_PAGELEN, v);
		check_val("pagelen", `SCD_PAGELEN_RST, v);
		reg_r(4'hf, v);
		check_val("unmapped", 0, v);
		// selector boundaries first, then random ones
		for (k = 0; k < 14; k++) begin
			r = rnd();
			@(posedge clk);
			proto_early <= r[9];
			x0 = n_x;
			p0 = n_p;
			ok = (k < 8) ? (k >= 1 && k <= 6) : (r[7:0] >= 8'h01 && r[7:0] <= 8'h06);
			run(mk_sec((k < 8) ? 8'(k) : r[7:0], r[8], {rnd(), rnd()}), 200,
				ok ? E_GOOD : E_ILL);
			check_val("xfer_start", ok, n_x - x0);
			if (ok) check_val("bytes", r[8] ? {cmd.len, 9'h000} : cmd.len, xfer.bytes);
			if (ok) check_val("protocol", cmd.b1, xfer.protocol);
			if (ok) check_val("early", r[9], xfer.early_good);
			if (ok) check_val("good_after_proc", !r[9], n_p - p0);
			repeat (30) @(posedge clk);
		end
		$display("test protocol-out done");
		spindle_ready <= 1'b0;
		run(diag(3'h5, 1'b1, 1'b1, 16'h0010), 20, E_NRDY);
		spindle_ready <= 1'b1;
		run(diag(3'h1, 1'b0, 1'b1, 16'h0001), 20, E_ILL);
		reg_w(`SCD_REG_PAGELEN, 16'h001c);
		run(diag(3'h1, 1'b1, 1'b0, 16'h001b), 20, E_ILL);
		run(diag(3'h3, 1'b0, 1'b0, 16'h0000), 20, E_ILL);
		run(diag(3'h7, 1'b0, 1'b0, 16'h0000), 20, E_ILL);
		run(diag(3'h4, 1'b0, 1'b0, 16'h0000), 20, E_ILL);
		lat = 10'd30;
		// default test: function code and page format are ignored
		for (k = 0; k < 2; k++) begin
			fault_in = k[0];
			r = rnd();
			// first pass sends code zero, the second shows a random code is ignored
			if (k == 0) r[2:0] = `SCD_FC_DEFAULT;
			run(diag(r[2:0], 1'b1, 1'b1, 16'h0000), 300, k ? E_FLT : E_GOOD);
			check_val("default_start", `SCD_FC_FG_SHORT, last_ts);
		end
		fault_in = 1'b0;
		for (k = 5; k < 7; k++) begin
			run(diag(3'(k), 1'b0, 1'b0, 16'h0000), 300, E_GOOD);
			check_val("fg_start", k, last_ts);
		end
		lat = 10'd200;
		run(diag(`SCD_FC_FG_SHORT, 1'b0, 1'b0, 16'h0000), 300, E_FLT);
		repeat (220) @(posedge clk);
		$display("test foreground done");
		lat = 10'd60;
		run(diag(`SCD_FC_BG_SHORT, 1'b1, 1'b0, 16'h001c), 20, E_GOOD);
		check_val("bg_start", `SCD_FC_BG_SHORT, last_ts);
		reg_r(`SCD_REG_STAT, v);
		check_val("stat_bg", {12'h002, 4'(scd_pkg::SCD_IDLE)}, v);
		x0 = n_ab;
		run(diag(`SCD_FC_ABORT, 1'b0, 1'b0, 16'h0000), 20, E_GOOD);
		check_val("abort", 1, n_ab - x0);
		fault_in = 1'b1;
		run(diag(`SCD_FC_BG_EXT, 1'b0, 1'b0, 16'h0000), 20, E_GOOD);
		check_val("bg_start", `SCD_FC_BG_EXT, last_ts);
		// the command's own ending pulse is counted one edge later
		@(posedge clk);
		#1 e0 = n_e;
		repeat (80) @(posedge clk);
		check_val("bg_fault_end", 0, n_e - e0);
		reg_r(`SCD_REG_LOG, v);
		check_val("log", 1, v);
		$display("test background done");
		// interrupt: one mask setting passes it, the other holds it back
		reg_r(`SCD_REG_IRQ, v);
		run(diag(3'h3, 1'b0, 1'b0, 16'h0000), 20, E_ILL);
		reg_w(`SCD_REG_MASK, 16'h0000);
		@(posedge clk);
		#1 ia = irq;
		reg_w(`SCD_REG_MASK, 16'hffff);
		@(posedge clk);
		#1 check_val("irq_mask", 1, ia ^ irq);
		reg_r(`SCD_REG_IRQ, v);
		check_val("irq_status", 2'b11, v[1:0]);
		@(posedge clk);
		#1 check_val("irq_clear", 0, irq);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
